/* common/itm_pkg.sv */
/*
 * constants for the ide channel timing block: config offsets, field
 * positions, reset values, cycle counts and the code-to-clocks decoders.
 * assumes nothing of its surroundings.
 */
package itm_pkg;
    // config space offsets (byte addresses)
    localparam logic [7:0]  PRI_TIMING_OFS  = 8'h40;
    localparam logic [7:0]  SEC_TIMING_OFS  = 8'h42;
    localparam logic [7:0]  DRV1_TIMING_OFS = 8'h44;
    // reset values
    localparam logic [15:0] TIMING_RESET    = 16'h0000;
    localparam logic [7:0]  DRV1_RESET      = 8'h00;
    // bits 11:10 are reserved and read as zero
    localparam logic [15:0] TIMING_WR_MASK  = 16'hf3ff;
    // channel timing field positions
    localparam int DECODE_EN_BIT   = 15;
    localparam int SEP_SELECT_BIT  = 14;
    localparam int SAMPLE_LO       = 12;
    localparam int RECOV_LO        = 8;
    localparam int D1_DMA_ONLY_BIT = 7;
    localparam int D1_POST_BIT     = 6;
    localparam int D1_RDY_EN_BIT   = 5;
    localparam int D1_BANK_BIT     = 4;
    localparam int D0_DMA_ONLY_BIT = 3;
    localparam int D0_POST_BIT     = 2;
    localparam int D0_RDY_EN_BIT   = 1;
    localparam int D0_BANK_BIT     = 0;
    // drive 1 timing register: 4 bits per channel, recovery low, sample high
    localparam int D1_FIELD_W      = 4;
    localparam int D1_SAMPLE_LO    = 2;
    // legacy i/o ports
    localparam logic [15:0] PRI_CMD_BASE = 16'h01f0;
    localparam logic [15:0] SEC_CMD_BASE = 16'h0170;
    localparam logic [15:0] PRI_CTL_PORT = 16'h03f6;
    localparam logic [15:0] SEC_CTL_PORT = 16'h0376;
    // cycle counts in clocks
    localparam logic [3:0]  SAMPLE_CLKS_SLOW = 4'h5;
    localparam logic [3:0]  SAMPLE_CLKS_FAST = 4'h3;
    localparam logic [3:0]  RECOV_CLKS_SLOW  = 4'h4;
    localparam logic [3:0]  COMPAT_SAMPLE    = 4'h8;
    localparam logic [3:0]  COMPAT_RECOV     = 4'h8;

    // 00=5, 01=4, 10=3; reserved 11 falls back to 3
    function automatic logic [3:0] sample_clks(input logic [1:0] code);
        return (code == 2'b11) ? SAMPLE_CLKS_FAST : SAMPLE_CLKS_SLOW - {2'b00, code};
    endfunction

    // 00=4, 01=3, 10=2, 11=1
    function automatic logic [3:0] recov_clks(input logic [1:0] code);
        return RECOV_CLKS_SLOW - {2'b00, code};
    endfunction
endpackage

/* rtl/itm_ide_channel_timing.sv */
/*
 * per-channel ide cable timing control: two channel timing registers,
 * the drive 1 timing register, legacy i/o decode and two strobe sequencers.
 * assumes config accesses and i/o decode requests come from logic on the
 * same clock; iordy comes straight from the cable pins.
 */
// Functional notes
// - decode enable claims command block and control port of the channel
// - per-channel disable inputs stop legacy decode even when enabled
// - separate select clear: shared sample and recovery fields serve both drives
// - separate select set: drive 1 takes its fields from drive 1 register
// - first iordy sample 5, 4 or 3 clocks after strobe; code 11 reserved
// - recovery of 4, 3, 2 or 1 clocks before the next strobe
// - drive 1 dma-only bit gives fast dma, compatible pio
// - drive 0 dma-only bit gives fast dma, compatible pio
// - drive 1 post bit enables prefetch and posting on data port
// - drive 0 post bit enables prefetch and posting on data port
// - drive 1 iordy sampled only when its ready enable is set
// - drive 0 iordy sampled only when its ready enable is set
// - drive 1 data port: compatible, shared fields, or drive 1 register
// - drive 0 data port: compatible, or shared sample and recovery fields
// - one 16-bit timing register per channel, reset to zero
// - drive 1 register holds sample and recovery codes per channel
`timescale 1ns/1ps
module itm_ide_channel_timing #(
    parameter int CHANNELS = 2
) (
    input  wire logic                clock,
    input  wire logic                reset,
    input  wire logic [7:0]          cfg_addr,
    input  wire logic                cfg_wr,
    input  wire logic                cfg_rd,
    input  wire logic [1:0]          cfg_be,
    input  wire logic [15:0]         cfg_wdata,
    output logic      [15:0]         cfg_rdata,
    input  wire logic                primary_decode_disable,
    input  wire logic                secondary_decode_disable,
    input  wire logic                io_valid,
    input  wire logic [15:0]         io_addr,
    output logic                     io_claim,
    output logic                     io_claim_secondary,
    input  wire logic [CHANNELS-1:0] req_valid,
    input  wire logic [CHANNELS-1:0] req_drive,
    input  wire logic [CHANNELS-1:0] req_dma,
    input  wire logic [CHANNELS-1:0] req_data_port,
    output logic      [CHANNELS-1:0] req_ready,
    input  wire logic [CHANNELS-1:0] iordy,
    output logic      [CHANNELS-1:0] cable_strobe,
    output logic      [CHANNELS-1:0] cycle_done,
    output logic      [CHANNELS-1:0] cycle_prefetch_post
);
    ////////////////////////////////////////////////////////////////////////
    // register state

    logic [15:0] chan_timing [CHANNELS];
    logic [7:0]  drive1_timing_register;
    logic        cfg_pri_hit;
    logic        cfg_sec_hit;
    logic        cfg_d1_hit;

    // word-aligned decode, so bit 0 of the address is ignored
    assign cfg_pri_hit = cfg_addr[7:1] == itm_pkg::PRI_TIMING_OFS[7:1];
    assign cfg_sec_hit = cfg_addr[7:1] == itm_pkg::SEC_TIMING_OFS[7:1];
    assign cfg_d1_hit  = cfg_addr[7:1] == itm_pkg::DRV1_TIMING_OFS[7:1];

    // channel timing registers, byte-lane writes, reserved bits held zero
    always_ff @(posedge clock) begin
        if (reset) begin
            for (int c = 0; c < CHANNELS; c++) begin
                chan_timing[c] <= itm_pkg::TIMING_RESET;
            end
        end else begin
            for (int c = 0; c < CHANNELS; c++) begin
                if (cfg_wr && (c == 0 ? cfg_pri_hit : cfg_sec_hit)) begin
                    if (cfg_be[0]) begin
                        chan_timing[c][7:0] <= cfg_wdata[7:0];
                    end
                    if (cfg_be[1]) begin
                        chan_timing[c][15:8] <= cfg_wdata[15:8] & itm_pkg::TIMING_WR_MASK[15:8];
                    end
                end
            end
        end
    end

    // drive 1 timing register is a single byte on the low lane
    always_ff @(posedge clock) begin
        if (reset) begin
            drive1_timing_register <= itm_pkg::DRV1_RESET;
        end else if (cfg_wr && cfg_d1_hit && cfg_be[0]) begin
            drive1_timing_register <= cfg_wdata[7:0];
        end
    end

    // read data one clock after cfg_rd; unmapped offsets read zero
    always_ff @(posedge clock) begin
        if (reset) begin
            cfg_rdata <= 16'h0000;
        end else if (cfg_rd && cfg_pri_hit) begin
            cfg_rdata <= chan_timing[0];
        end else if (cfg_rd && cfg_sec_hit) begin
            cfg_rdata <= chan_timing[CHANNELS-1];
        end else if (cfg_rd && cfg_d1_hit) begin
            cfg_rdata <= {8'h00, drive1_timing_register};
        end else begin
            cfg_rdata <= 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // legacy i/o decode

    logic pri_decode;
    logic sec_decode;
    logic pri_match;
    logic sec_match;

    // disables win over the enable so an external controller can own a range
    assign pri_decode = chan_timing[0][itm_pkg::DECODE_EN_BIT] && !primary_decode_disable;
    assign sec_decode = chan_timing[CHANNELS-1][itm_pkg::DECODE_EN_BIT] && !secondary_decode_disable;
    assign pri_match  = io_addr[15:3] == itm_pkg::PRI_CMD_BASE[15:3] || io_addr == itm_pkg::PRI_CTL_PORT;
    assign sec_match  = io_addr[15:3] == itm_pkg::SEC_CMD_BASE[15:3] || io_addr == itm_pkg::SEC_CTL_PORT;

    // claim is registered, one clock after io_valid
    always_ff @(posedge clock) begin
        if (reset) begin
            io_claim           <= 1'b0;
            io_claim_secondary <= 1'b0;
        end else begin
            io_claim           <= io_valid && ((pri_decode && pri_match) || (sec_decode && sec_match));
            io_claim_secondary <= io_valid && sec_decode && sec_match;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-channel profile selection and strobe sequencing

    logic [3:0] sel_sample [CHANNELS];
    logic [3:0] sel_recov  [CHANNELS];
    logic       sel_fast   [CHANNELS];
    logic       sel_post   [CHANNELS];
    logic       sel_rdy_en [CHANNELS];
    logic       seq_start  [CHANNELS];

    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
        logic [15:0] tim;
        logic [3:0]  d1_field;
        logic        drv1;
        logic        bank;
        logic        dma_only;
        logic        use_d1;
        logic [1:0]  sample_code;
        logic [1:0]  recov_code;

        assign tim      = chan_timing[ch];
        assign d1_field = drive1_timing_register[ch*itm_pkg::D1_FIELD_W +: itm_pkg::D1_FIELD_W];
        assign drv1     = req_drive[ch];

        // per-drive bits picked by the requested drive
        assign bank       = drv1 ? tim[itm_pkg::D1_BANK_BIT] : tim[itm_pkg::D0_BANK_BIT];
        assign dma_only   = drv1 ? tim[itm_pkg::D1_DMA_ONLY_BIT] : tim[itm_pkg::D0_DMA_ONLY_BIT];
        assign sel_rdy_en[ch] = drv1 ? tim[itm_pkg::D1_RDY_EN_BIT]
                                     : tim[itm_pkg::D0_RDY_EN_BIT];

        // dma-only bit keeps pio at compatible timing but speeds up dma
        always_comb begin
            if (req_dma[ch]) begin
                sel_fast[ch] = bank || dma_only;
            end else begin
                sel_fast[ch] = req_data_port[ch] && bank && !dma_only;
            end
        end

        // drive 1 borrows the separate register only when selected
        assign use_d1      = drv1 && tim[itm_pkg::SEP_SELECT_BIT];
        assign sample_code = use_d1 ? d1_field[itm_pkg::D1_SAMPLE_LO +: 2] : tim[itm_pkg::SAMPLE_LO +: 2];
        assign recov_code  = use_d1 ? d1_field[1:0] : tim[itm_pkg::RECOV_LO +: 2];

        // compatible profile is slower than any fast code
        assign sel_sample[ch] = sel_fast[ch] ? itm_pkg::sample_clks(sample_code)
                                             : itm_pkg::COMPAT_SAMPLE;
        assign sel_recov[ch]  = sel_fast[ch] ? itm_pkg::recov_clks(recov_code)
                                             : itm_pkg::COMPAT_RECOV;

        // posting only applies to pio data port cycles
        assign sel_post[ch] = req_data_port[ch] && !req_dma[ch]
                              && (drv1 ? tim[itm_pkg::D1_POST_BIT] : tim[itm_pkg::D0_POST_BIT]);

        assign seq_start[ch] = req_valid[ch] && req_ready[ch];

        // prefetch/post flag held for the whole cycle
        always_ff @(posedge clock) begin
            if (reset) begin
                cycle_prefetch_post[ch] <= 1'b0;
            end else if (seq_start[ch]) begin
                cycle_prefetch_post[ch] <= sel_post[ch];
            end
        end

        itm_strobe_seq u_seq (
            .clock       (clock),
            .reset       (reset),
            .start       (seq_start[ch]),
            .sample_clks (sel_sample[ch]),
            .recov_clks  (sel_recov[ch]),
            .ready_en    (sel_rdy_en[ch]),
            .iordy_pin   (iordy[ch]),
            .ready       (req_ready[ch]),
            .strobe      (cable_strobe[ch]),
            .done        (cycle_done[ch])
        );

        chk_post_pick: assert property (@(posedge clock) disable iff (reset)
            seq_start[ch] && !drv1 |=> cycle_prefetch_post[ch]
                == $past(tim[itm_pkg::D0_POST_BIT] && req_data_port[ch] && !req_dma[ch]))
            else $error("prefetch flag wrong for drive 0");

        chk_d0_profile: assert property (@(posedge clock) disable iff (reset)
            seq_start[ch] && !drv1 && req_data_port[ch] && !req_dma[ch] && !tim[itm_pkg::D0_DMA_ONLY_BIT]
            |-> sel_sample[ch] == (tim[itm_pkg::D0_BANK_BIT]
                ? itm_pkg::sample_clks(tim[13:12]) : itm_pkg::COMPAT_SAMPLE))
            else $error("drive 0 sample point wrong");

        chk_d1_separate: assert property (@(posedge clock) disable iff (reset)
            seq_start[ch] && drv1 && sel_fast[ch] && tim[itm_pkg::SEP_SELECT_BIT]
            |-> sel_recov[ch] == itm_pkg::recov_clks(d1_field[1:0]))
            else $error("drive 1 recovery not from drive 1 register");
    end

    ////////////////////////////////////////////////////////////////////////
    // checks on decode and reset

    chk_decode_claim: assert property (@(posedge clock) disable iff (reset)
        io_valid && pri_decode && io_addr == itm_pkg::PRI_CTL_PORT
        |=> io_claim && !io_claim_secondary)
        else $error("primary control port not claimed");

    chk_decode_off: assert property (@(posedge clock) disable iff (reset)
        primary_decode_disable && secondary_decode_disable ##1 1'b1 |-> !io_claim)
        else $error("claim while both channels disabled");

    chk_reg_reset: assert property (@(posedge clock)
        $past(reset) && !reset |-> chan_timing[0] == itm_pkg::TIMING_RESET
            && chan_timing[CHANNELS-1] == itm_pkg::TIMING_RESET
            && drive1_timing_register == itm_pkg::DRV1_RESET && cfg_rdata == 16'h0000)
        else $error("registers not zero after reset");
endmodule

/* rtl/itm_strobe_seq.sv */
/*
 * one channel's cable strobe sequencer: strobe, iordy sample, recovery.
 * assumes counts of at least one and a raw iordy pin from the cable.
 */
`timescale 1ns/1ps
module itm_strobe_seq (
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic       start,
    input  wire logic [3:0] sample_clks,
    input  wire logic [3:0] recov_clks,
    input  wire logic       ready_en,
    input  wire logic       iordy_pin,
    output logic            ready,
    output logic            strobe,
    output logic            done
);
    typedef enum logic [1:0] {
        ITM_IDLE    = 2'b00,
        ITM_STROBE  = 2'b01,
        ITM_RECOVER = 2'b10
    } itm_seq_state_t;

    itm_seq_state_t state;
    logic [3:0]     cnt;
    logic [3:0]     recov_hold;
    logic           rdy_en_hold;
    logic           iordy_meta;
    logic           iordy_sync;

    // pin crosses in through two flops
    always_ff @(posedge clock) begin
        iordy_meta <= iordy_pin;
        iordy_sync <= iordy_meta;
    end

    ////////////////////////////////////////////////////////////////////////
    // strobe, sample and recovery; the drive may stretch via iordy
    always_ff @(posedge clock) begin
        if (reset) begin
            state  <= ITM_IDLE;
            cnt    <= 4'h0;
            recov_hold  <= 4'h0;
            rdy_en_hold <= 1'b0;
            ready  <= 1'b1;
            strobe <= 1'b0;
            done   <= 1'b0;
        end else begin
            done <= 1'b0;
            unique case (state)
                ITM_IDLE: begin
                    if (start) begin
                        strobe <= 1'b1;
                        ready  <= 1'b0;
                        cnt    <= sample_clks - 4'h1;
                        // profile frozen at take; inputs may move mid-cycle
                        recov_hold  <= recov_clks;
                        rdy_en_hold <= ready_en;
                        state  <= ITM_STROBE;
                    end
                end
                ITM_STROBE: begin
                    if (cnt != 4'h0) begin
                        cnt <= cnt - 4'h1;
                    end else if (!rdy_en_hold || iordy_sync) begin
                        strobe <= 1'b0;
                        done   <= 1'b1;
                        cnt    <= recov_hold - 4'h1;
                        state  <= ITM_RECOVER;
                    end
                end
                ITM_RECOVER: begin
                    if (cnt != 4'h0) begin
                        cnt <= cnt - 4'h1;
                    end else begin
                        ready <= 1'b1;
                        state <= ITM_IDLE;
                    end
                end
                default: state <= ITM_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // helper counts for the checks below
    logic [3:0] hi_len;
    logic [3:0] lo_len;
    logic [3:0] want_sample;
    logic [3:0] want_recov;
    logic       want_rdy;
    always_ff @(posedge clock) begin
        if (reset) begin
            hi_len      <= 4'h0;
            lo_len      <= 4'hf;
            want_sample <= 4'h0;
            want_recov  <= 4'h0;
            want_rdy    <= 1'b0;
        end else begin
            hi_len <= strobe ? hi_len + 4'h1 : 4'h0;
            lo_len <= strobe ? 4'h0 : (lo_len == 4'hf ? lo_len : lo_len + 4'h1);
            if (start && ready) begin
                want_sample <= sample_clks;
                want_recov  <= recov_clks;
                want_rdy    <= ready_en;
            end
        end
    end

    sequence s_strobe_end;
        $fell(strobe);
    endsequence

    chk_sample_exact: assert property (@(posedge clock) disable iff (reset)
        s_strobe_end and !want_rdy |-> hi_len == want_sample)
        else $error("strobe width differs from sample point");
    chk_sample_least: assert property (@(posedge clock) disable iff (reset)
        s_strobe_end |-> hi_len >= want_sample)
        else $error("iordy sampled before sample point");
    chk_recovery_gap: assert property (@(posedge clock) disable iff (reset)
        $rose(strobe) |-> lo_len >= $past(want_recov))
        else $error("recovery time too short");
    chk_ready_wait: assert property (@(posedge clock) disable iff (reset)
        state == ITM_STROBE && cnt == 4'h0 && want_rdy && !iordy_sync |=> strobe)
        else $error("strobe ended while drive not ready");
    chk_done_fall: assert property (@(posedge clock) disable iff (reset)
        done |-> s_strobe_end)
        else $error("done without strobe end");
endmodule

/* test/itm_drive_model.sv */
/*
 * behavioural ide drive: answers each channel's strobe on the ready line.
 * assumes one strobe per cycle and a pulled-up ready line on the cable.
 */
`timescale 1ns/1ps
module itm_drive_model (
    input  wire logic       clock,
    input  wire logic [1:0] cable_strobe,
    input  wire logic [7:0] stall_clks,
    output logic      [1:0] iordy
);
    logic [7:0] held [2];

    // clocks of strobe seen so far, per channel
    always_ff @(posedge clock) begin
        for (int c = 0; c < 2; c++) begin
            held[c] <= cable_strobe[c] ? held[c] + 8'h01 : 8'h00;
        end
    end

    // slow drive holds ready low; released line floats high by pull-up
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            iordy[c] = !(cable_strobe[c] && (held[c] < stall_clks));
        end
    end
endmodule

/* test/itm_ide_channel_timing_tb.sv */
/*
 * self-checking bench for the ide channel timing block.
 * assumes the drive model beside it and the design's two channels.
 */
`timescale 1ns/1ps
module itm_ide_channel_timing_tb;
    logic clock = 1'b0, reset = 1'b1;
    logic [7:0] cfg_addr = 8'h00;
    logic cfg_wr = 1'b0, cfg_rd = 1'b0, io_valid = 1'b0;
    logic [1:0] cfg_be = 2'h3, req_valid = 2'h0, req_drive = 2'h0, req_dma = 2'h0, req_dp = 2'h0;
    logic [15:0] cfg_wdata = 16'h0000, io_addr = 16'h0000, cfg_rdata;
    logic pri_dis = 1'b0, sec_dis = 1'b0, io_claim, io_claim_sec;
    logic [1:0] req_ready, iordy, cable_strobe, cycle_done, cycle_pp;
    logic [7:0] stall = 8'h00;
    int n_errors = 0, num_checks = 0, last_n;

    itm_ide_channel_timing dut (.clock(clock), .reset(reset), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
        .cfg_rd(cfg_rd), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .primary_decode_disable(pri_dis), .secondary_decode_disable(sec_dis), .io_valid(io_valid),
        .io_addr(io_addr), .io_claim(io_claim), .io_claim_secondary(io_claim_sec), .req_valid(req_valid),
        .req_drive(req_drive), .req_dma(req_dma), .req_data_port(req_dp), .req_ready(req_ready),
        .iordy(iordy), .cable_strobe(cable_strobe), .cycle_done(cycle_done), .cycle_prefetch_post(cycle_pp));
    itm_drive_model drv (.clock(clock), .cable_strobe(cable_strobe), .stall_clks(stall), .iordy(iordy));

    // 250 mhz
    always #2 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one-cycle strobes, launched just after an edge
    task automatic cfg_write(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be);
        @(posedge clock); #1;
        cfg_addr = a; cfg_wdata = d; cfg_be = be; cfg_wr = 1'b1;
        @(posedge clock); #1;
        cfg_wr = 1'b0;
    endtask

    task automatic cfg_read(input logic [7:0] a, output logic [15:0] d);
        @(posedge clock); #1;
        cfg_addr = a; cfg_rd = 1'b1;
        @(posedge clock); #1;
        cfg_rd = 1'b0;
        d = cfg_rdata;
    endtask

    task automatic io_probe(input logic [15:0] a, input logic claim, input logic sec);
        @(posedge clock); #1;
        io_addr = a; io_valid = 1'b1;
        @(posedge clock); #1;
        io_valid = 1'b0;
        check(io_claim, claim);
        check(io_claim_sec, sec);
    endtask

    // es of zero skips the strobe length compare; length left in last_n
    task automatic cyc(input int ch, input logic d1, input logic dma, input logic dp,
                       input int es, input int er, input logic pp);
        int m;
        @(posedge clock); #1;
        req_valid[ch] = 1'b1; req_drive[ch] = d1; req_dma[ch] = dma; req_dp[ch] = dp;
        @(posedge clock); #1;
        req_valid[ch] = 1'b0;
        check(cable_strobe[ch], 1'b1);
        check(cycle_pp[ch], pp);
        last_n = 0;
        while (cable_strobe[ch] === 1'b1 && last_n < 200) begin
            @(posedge clock); #1;
            last_n++;
        end
        if (es != 0) check(16'(last_n), 16'(es));
        check(cycle_done[ch], 1'b1);
        m = 0;
        while (req_ready[ch] !== 1'b1 && m < 200) begin
            @(posedge clock); #1;
            m++;
        end
        if (m >= 200 || last_n >= 200) begin
            n_errors++;
            tally_and_finish();
        end
        check(16'(m), 16'(er));
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic sc_registers();
        logic [15:0] d;
        cfg_read(8'h40, d); check(d, 16'h0000);
        cfg_read(8'h42, d); check(d, 16'h0000);
        cfg_read(8'h44, d); check(d, 16'h0000);
        cfg_write(8'h40, 16'hffff, 2'h3);
        cfg_read(8'h40, d); check(d, 16'hf3ff);
        cfg_write(8'h40, 16'h0000, 2'h1);
        cfg_read(8'h40, d); check(d, 16'hf300);
        cfg_read(8'h42, d); check(d, 16'h0000);
        cfg_write(8'h44, 16'hffff, 2'h3);
        cfg_read(8'h44, d); check(d, 16'h00ff);
        cfg_write(8'h46, 16'hffff, 2'h3);
        cfg_read(8'h46, d); check(d, 16'h0000);
    endtask

    task automatic sc_decode();
        cfg_write(8'h40, 16'h8000, 2'h3);
        cfg_write(8'h42, 16'h0000, 2'h3);
        io_probe(16'h01f0, 1'b1, 1'b0);
        io_probe(16'h01f7, 1'b1, 1'b0);
        io_probe(16'h03f6, 1'b1, 1'b0);
        io_probe(16'h01f8, 1'b0, 1'b0);
        io_probe(16'h0170, 1'b0, 1'b0);
        cfg_write(8'h42, 16'h8000, 2'h3);
        io_probe(16'h0177, 1'b1, 1'b1);
        io_probe(16'h0376, 1'b1, 1'b1);
        pri_dis = 1'b1;
        io_probe(16'h01f2, 1'b0, 1'b0);
        io_probe(16'h0172, 1'b1, 1'b1);
        sec_dis = 1'b1;
        io_probe(16'h0376, 1'b0, 1'b0);
        pri_dis = 1'b0;
        sec_dis = 1'b0;
    endtask

    // reserved sample code 11 is never programmed
    task automatic sc_codes();
        for (int c = 0; c < 4; c++) begin
            cfg_write(8'h40, 16'h8001 | 16'((c > 2 ? 2 : c) << 12) | 16'(c << 8), 2'h3);
            cyc(0, 1'b0, 1'b0, 1'b1, 5 - (c > 2 ? 2 : c), 4 - c, 1'b0);
        end
        cfg_write(8'h40, 16'ha300, 2'h3);
        cyc(0, 1'b0, 1'b0, 1'b1, 8, 8, 1'b0);
        cfg_write(8'h42, 16'h9101, 2'h3);
        cyc(1, 1'b0, 1'b0, 1'b1, 4, 3, 1'b0);
    endtask

    task automatic sc_banks();
        cfg_write(8'h40, 16'ha388, 2'h3);
        cyc(0, 1'b0, 1'b1, 1'b0, 3, 1, 1'b0);
        cyc(0, 1'b0, 1'b0, 1'b1, 8, 8, 1'b0);
        cyc(0, 1'b1, 1'b1, 1'b0, 3, 1, 1'b0);
        cyc(0, 1'b1, 1'b0, 1'b1, 8, 8, 1'b0);
        cfg_write(8'h40, 16'ha311, 2'h3);
        cyc(0, 1'b1, 1'b0, 1'b1, 3, 1, 1'b0);
        cfg_write(8'h44, 16'h0006, 2'h1);
        cfg_write(8'h40, 16'he311, 2'h3);
        cyc(0, 1'b1, 1'b0, 1'b1, 4, 2, 1'b0);
        cyc(0, 1'b0, 1'b0, 1'b1, 3, 1, 1'b0);
        cfg_write(8'h40, 16'h8000, 2'h3);
        cyc(0, 1'b1, 1'b0, 1'b1, 8, 8, 1'b0);
    endtask

    task automatic sc_ready_post();
        stall = 8'd10;
        cfg_write(8'h40, 16'h8001, 2'h3);
        cyc(0, 1'b0, 1'b0, 1'b1, 5, 4, 1'b0);
        cfg_write(8'h40, 16'h8003, 2'h3);
        cyc(0, 1'b0, 1'b0, 1'b1, 0, 4, 1'b0);
        check(16'(last_n > 5), 16'h0001);
        cfg_write(8'h40, 16'h8030, 2'h3);
        cyc(0, 1'b1, 1'b0, 1'b1, 0, 4, 1'b0);
        check(16'(last_n > 5), 16'h0001);
        stall = 8'd0;
        cfg_write(8'h40, 16'h8055, 2'h3);
        cyc(0, 1'b1, 1'b0, 1'b1, 5, 4, 1'b1);
        cyc(0, 1'b0, 1'b0, 1'b1, 5, 4, 1'b1);
        cyc(0, 1'b0, 1'b1, 1'b0, 5, 4, 1'b0);
        cfg_write(8'h40, 16'h8011, 2'h3);
        cyc(0, 1'b1, 1'b0, 1'b1, 5, 4, 1'b0);
    endtask

    // mid-run reset must clear the primary timing and drive 1 timing registers again
    task automatic sc_reset();
        logic [15:0] d;
        cfg_write(8'h44, 16'h00ff, 2'h1);
        @(posedge clock); #1 reset = 1'b1;
        repeat (2) @(posedge clock);
        #1 reset = 1'b0;
        check(req_ready, 2'h3);
        cfg_read(8'h40, d); check(d, 16'h0000);
        cfg_read(8'h44, d); check(d, 16'h0000);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clock);
        #1 reset = 1'b0;
        check(req_ready, 2'h3);
        sc_registers();
        sc_decode();
        sc_codes();
        sc_banks();
        sc_ready_post();
        sc_reset();
        tally_and_finish();
    end
endmodule
